// File: verilog/hwq_wave_engine.sv
`timescale 1ns/10ps
// Function
// - No stored effects: whole memory feeds queue
// - Capacity shrinks by stored effect entries
// - Capacity register reports total queue size
// - Free register: zero full, capacity empty
// - Almost-empty pin low at low-water time
// - Low-water thresholds follow rate/time table
// - Sixteen effects, 8-bit loop counts default one
// - Loop count zero replays until trigger cleared
// - Trigger starts playback, self-clears when done
// - Pumps up, ramp to 10V, then samples
// - Standby when idle, power sequenced automatically
// - Decode registers and sample memory windows
// - Top 1024 entries hidden from host
// - Effect starts follow previous end pointer
// - Capacity from stored count and last end
// - Play slots in order via effect index
// - Finish slot repetitions before advancing
// - Queue write enqueues low 12 bits
// - Queue writes ignored while full
// - Sample clock 8, 32 or 48 kHz
module hwq_wave_engine
  import hwq_pkg::*;
#(
  parameter int PUMP_TMO_CYC = PUMP_CYC,
  parameter int DIV8_CYC     = DIV_8K_CYC,
  parameter int DIV32_CYC    = DIV_32K_CYC,
  parameter int DIV48_CYC    = DIV_48K_CYC
) (
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  input  wire logic   spi_sclk,
  input  wire logic   spi_cs_n,
  input  wire logic   spi_mosi,
  output logic        spi_miso,
  output logic        spi_miso_oe_n,
  input  wire logic   pump_ok,
  input  wire logic   ramp_done,
  output hwq_pwr_t    pwr_ctl,
  output logic [11:0] dac_data,
  output logic        dac_strobe,
  output logic        fifo_low_n
);

  if (DIV8_CYC < 2 || DIV8_CYC > 65536 || DIV32_CYC < 2 || DIV32_CYC > 65536 ||
      DIV48_CYC < 2 || DIV48_CYC > 65536 || PUMP_TMO_CYC < 1) begin : g_chk
    $error("hwq_wave_engine: divider or timeout parameter out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic       sclk3_q;
  wire  logic [4:0] pins = {ramp_done, pump_ok, spi_mosi, spi_cs_n, spi_sclk};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q    <= 5'h02;
      s2_q    <= 5'h02;
      sclk3_q <= 1'b0;
    end else begin
      s1_q    <= pins;
      s2_q    <= s1_q;
      sclk3_q <= s2_q[0];
    end
  end

  wire logic cs_n_s  = s2_q[1];
  wire logic mosi_s  = s2_q[2];
  wire logic pump_s  = s2_q[3];
  wire logic ramp_s  = s2_q[4];
  wire logic sck_up  = s2_q[0] & ~sclk3_q & ~cs_n_s;
  wire logic sck_dn  = ~s2_q[0] & sclk3_q & ~cs_n_s;

  // ----------------------------------------------------------------
  // SPI slave: command word then data words
  // ----------------------------------------------------------------
  logic [15:0] sh_q;
  logic [15:0] tx_q;
  logic [13:0] addr_q;
  logic [3:0]  bit_q;
  logic        first_q;
  logic        rd_q;
  logic        miso_q;
  logic        oe_n_q;
  logic [15:0] rdata;

  wire logic [15:0] rx_word  = {sh_q[14:0], mosi_s};
  wire logic        word_end = sck_up & (bit_q == 4'hf);
  wire logic        at_qport = (addr_q == {6'h00, OFS_QPORT});
  wire logic [13:0] nxt_addr = first_q  ? rx_word[13:0] :
                               at_qport ? addr_q : 14'(addr_q + 14'h0001);
  wire logic        rd_load  = word_end & (first_q ? rx_word[15] : rd_q);
  wire logic        wr_en    = word_end & ~first_q & ~rd_q;
  wire logic        wreg     = wr_en & (addr_q[13:8] == 6'h00);
  wire logic        wram     = wr_en & addr_q[13];
  wire logic [7:0]  wa       = addr_q[7:0];

  always_ff @(posedge core_clk) begin
    if (!rst_n || cs_n_s) begin
      bit_q   <= 4'h0;
      first_q <= 1'b1;
      rd_q    <= 1'b0;
      addr_q  <= 14'h0000;
      sh_q    <= 16'h0000;
    end else if (sck_up) begin
      sh_q  <= rx_word;
      bit_q <= 4'(bit_q + 4'h1);
      if (word_end) begin
        first_q <= 1'b0;
        addr_q  <= nxt_addr;
        if (first_q) begin
          rd_q <= rx_word[15];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_q   <= 16'h0000;
      miso_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= cs_n_s;
      if (rd_load) begin
        tx_q <= rdata;
      end else if (sck_dn) begin
        miso_q <= tx_q[15];
        tx_q   <= {tx_q[14:0], 1'b0};
      end
    end
  end

  assign spi_miso      = miso_q;
  assign spi_miso_oe_n = oe_n_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  hwq_cfg_t    cfg_q;
  logic [4:0]  nstored_q;
  logic [4:0]  nplay_q;
  logic        trig_q;
  logic [12:0] end_q  [N_EFFECTS];
  logic [3:0]  idx_q  [N_EFFECTS];
  logic [7:0]  loop_q [N_EFFECTS];
  logic        play_done;

  for (genvar i = 0; i < N_EFFECTS; i++) begin : g_slot
    wire logic hit = wreg & (wa[3:0] == 4'(i));
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        end_q[i]  <= 13'h0000;
        idx_q[i]  <= 4'h0;
        loop_q[i] <= LOOP_RST;
      end else if (hit) begin
        if (wa[7:4] == GRP_END)  end_q[i]  <= rx_word[12:0];
        if (wa[7:4] == GRP_IDX)  idx_q[i]  <= rx_word[3:0];
        if (wa[7:4] == GRP_LOOP) loop_q[i] <= rx_word[7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_q     <= CFG_RST;
      nstored_q <= 5'h00;
      nplay_q   <= 5'h00;
      trig_q    <= 1'b0;
    end else begin
      if (wreg && wa == OFS_CFG) cfg_q <= hwq_cfg_t'(rx_word[3:0]);
      if (wreg && wa == OFS_NSTORED && rx_word[15:0] <= 16'(N_EFFECTS))
        nstored_q <= rx_word[4:0];
      if (wreg && wa == OFS_NPLAY && rx_word[15:0] <= 16'(N_EFFECTS))
        nplay_q <= rx_word[4:0];
      // Host write wins over the self-clear in the same cycle
      if (wreg && wa == OFS_PLAY) trig_q <= rx_word[PLAY_TRIG_BIT];
      else if (play_done)        trig_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Queue sizing within the shared memory
  // ----------------------------------------------------------------
  logic [13:0] qcnt_q;
  logic [13:0] wp_q;
  logic [13:0] rp_q;

  wire logic [12:0] last_end = end_q[4'(nstored_q - 5'h01)];
  wire logic [13:0] stored_w = (nstored_q == 5'h00) ? 14'h0000 :
                               14'({1'b0, last_end} + 14'h0001);
  wire logic [13:0] cap      = 14'(14'(MEM_DEPTH) - stored_w);
  wire logic [13:0] free_w   = 14'(cap - qcnt_q);
  wire logic        q_full   = (qcnt_q >= cap);
  wire logic        push     = wreg & (wa == OFS_QPORT) & ~q_full;
  wire logic [13:0] q_wr_idx = 14'(stored_w + wp_q);
  wire logic [13:0] q_rd_idx = 14'(stored_w + rp_q);
  wire logic [13:0] cap_m1   = 14'(cap - 14'h0001);

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  hwq_state_t  st_q;
  logic        src_q;
  logic [3:0]  slot_q;
  wire  logic [7:0] ra     = nxt_addr[7:0];
  wire  logic       ra_reg = (nxt_addr[13:8] == 6'h00);

  assign rdata = !ra_reg               ? 16'h0000 :
                 ra == OFS_CFG         ? {12'h000, cfg_q} :
                 ra == OFS_CAP         ? {2'h0, cap} :
                 ra == OFS_FREE        ? {2'h0, free_w} :
                 ra == OFS_NSTORED     ? {11'h000, nstored_q} :
                 ra == OFS_NPLAY       ? {11'h000, nplay_q} :
                 ra == OFS_PLAY        ? {15'h0000, trig_q} :
                 ra == OFS_STATUS      ? {9'h000, slot_q, src_q, st_q} :
                 ra[7:4] == GRP_END    ? {3'h1, end_q[ra[3:0]]} :
                 ra[7:4] == GRP_IDX    ? {12'h000, idx_q[ra[3:0]]} :
                 ra[7:4] == GRP_LOOP   ? {8'h00, loop_q[ra[3:0]]} : 16'h0000;

  // ----------------------------------------------------------------
  // Sample clock divider
  // ----------------------------------------------------------------
  logic [15:0] div_q;
  wire  logic [1:0]  rate    = cfg_q.sample_rate_select;
  wire  logic [15:0] div_lim = (rate == 2'h0) ? 16'(DIV8_CYC - 1) :
                               (rate == 2'h1) ? 16'(DIV32_CYC - 1) :
                               16'(DIV48_CYC - 1);
  wire  logic        smp     = (div_q >= div_lim);

  always_ff @(posedge core_clk) begin
    if (!rst_n) div_q <= 16'h0000;
    else        div_q <= smp ? 16'h0000 : 16'(div_q + 16'h0001);
  end

  // ----------------------------------------------------------------
  // Playback sequencer
  // ----------------------------------------------------------------
  logic [12:0] ptr_q;
  logic [7:0]  rem_q;
  logic [31:0] tmr_q;

  wire logic [3:0]  cur_e    = idx_q[slot_q];
  wire logic [3:0]  nxt_e    = idx_q[4'(slot_q + 4'h1)];
  wire logic [12:0] st_cur   = (cur_e == 4'h0) ? 13'h0000 :
                               13'(end_q[4'(cur_e - 4'h1)] + 13'h0001);
  wire logic [12:0] st_nxt   = (nxt_e == 4'h0) ? 13'h0000 :
                               13'(end_q[4'(nxt_e - 4'h1)] + 13'h0001);
  wire logic        at_end   = (ptr_q == end_q[cur_e]);
  wire logic        loop_inf = (loop_q[slot_q] == 8'h00);
  wire logic        last_rep = ~loop_inf & (rem_q == 8'h01);
  wire logic        last_sl  = (5'(slot_q) + 5'h01 >= nplay_q);
  wire logic        run_ram  = (st_q == ST_RUN) & src_q & smp;
  wire logic        run_q    = (st_q == ST_RUN) & ~src_q & smp;
  wire logic        pop      = run_q & (qcnt_q != 14'h0000);
  wire logic        tmo      = (tmr_q == 32'(PUMP_TMO_CYC - 1));

  assign play_done = (run_ram & trig_q & at_end & last_rep & last_sl) |
                     (st_q == ST_PUMP & tmo & src_q) |
                     (st_q == ST_IDLE & trig_q & nplay_q == 5'h00);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q   <= ST_IDLE;
      src_q  <= 1'b0;
      slot_q <= 4'h0;
      ptr_q  <= 13'h0000;
      rem_q  <= 8'h00;
      tmr_q  <= 32'h0000_0000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          slot_q <= 4'h0;
          tmr_q  <= 32'h0000_0000;
          if (trig_q && nplay_q != 5'h00) begin
            src_q <= 1'b1;
            st_q  <= ST_PUMP;
          end else if (!trig_q && qcnt_q != 14'h0000) begin
            src_q <= 1'b0;
            st_q  <= ST_PUMP;
          end
        end
        ST_PUMP: begin
          tmr_q <= 32'(tmr_q + 32'h0000_0001);
          if (pump_s) st_q <= ST_RAMP;
          else if (tmo) st_q <= ST_IDLE;
        end
        ST_RAMP: begin
          if (ramp_s) begin
            st_q  <= ST_RUN;
            ptr_q <= st_cur;
            rem_q <= loop_q[slot_q];
          end
        end
        ST_RUN: begin
          if (src_q && smp) begin
            if (!trig_q) begin
              st_q <= ST_IDLE;
            end else if (!at_end) begin
              ptr_q <= 13'(ptr_q + 13'h0001);
            end else if (!last_rep) begin
              ptr_q <= st_cur;
              rem_q <= loop_inf ? rem_q : 8'(rem_q - 8'h01);
            end else if (last_sl) begin
              st_q <= ST_IDLE;
            end else begin
              slot_q <= 4'(slot_q + 4'h1);
              ptr_q  <= st_nxt;
              rem_q  <= loop_q[4'(slot_q + 4'h1)];
            end
          end else if (!src_q && smp && qcnt_q == 14'h0000) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shared sample memory and queue pointers
  // ----------------------------------------------------------------
  logic [11:0] mem [MEM_DEPTH];
  wire  logic        mem_we = wram | push;
  wire  logic [13:0] mem_wa = wram ? {1'b0, addr_q[12:0]} : q_wr_idx;
  wire  logic [13:0] rd_idx = src_q ? {1'b0, ptr_q} : q_rd_idx;

  always_ff @(posedge core_clk) begin
    if (mem_we) mem[mem_wa] <= rx_word[11:0];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      qcnt_q <= 14'h0000;
      wp_q   <= 14'h0000;
      rp_q   <= 14'h0000;
    end else begin
      if (push) wp_q <= (wp_q >= cap_m1) ? 14'h0000 : 14'(wp_q + 14'h0001);
      if (pop)  rp_q <= (rp_q >= cap_m1) ? 14'h0000 : 14'(rp_q + 14'h0001);
      if (push && !pop)      qcnt_q <= 14'(qcnt_q + 14'h0001);
      else if (pop && !push) qcnt_q <= 14'(qcnt_q - 14'h0001);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [11:0] dac_q;
  logic        stb_q;
  logic        low_n_q;
  hwq_pwr_t    pwr_q;
  wire  logic [1:0] rix = (rate == 2'h0) ? 2'h0 : (rate == 2'h1) ? 2'h1 : 2'h2;
  wire  logic [6:0] thr = LW_TAB[rix][cfg_q.low_water_time];
  wire  logic       emit = (run_ram & trig_q) | pop;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dac_q   <= 12'h000;
      stb_q   <= 1'b0;
      low_n_q <= 1'b0;
      pwr_q   <= '0;
    end else begin
      stb_q   <= emit;
      if (emit) dac_q <= mem[rd_idx];
      low_n_q <= (qcnt_q > {7'h00, thr});
      pwr_q.pump_en <= (st_q != ST_IDLE);
      pwr_q.gate_en <= (st_q == ST_RAMP) | (st_q == ST_RUN);
      pwr_q.out_en  <= (st_q == ST_RAMP) | (st_q == ST_RUN);
    end
  end

  assign dac_data   = dac_q;
  assign dac_strobe = stb_q;
  assign fifo_low_n = low_n_q;
  assign pwr_ctl    = pwr_q;

endmodule

// File: inc/hwq_pkg.sv
package hwq_pkg;

  // ----------------------------------------------------------------
  // Memory and timing
  // ----------------------------------------------------------------
  localparam int MEM_DEPTH   = 9216;
  localparam int CLK_HZ      = 250_000_000;
  localparam int PUMP_MAX_US = 2000;
  localparam int PUMP_CYC    = CLK_HZ / 1_000_000 * PUMP_MAX_US;
  localparam int RATE_8K_HZ  = 8000;
  localparam int RATE_32K_HZ = 32000;
  localparam int RATE_48K_HZ = 48000;
  localparam int DIV_8K_CYC  = CLK_HZ / RATE_8K_HZ;
  localparam int DIV_32K_CYC = CLK_HZ / RATE_32K_HZ;
  localparam int DIV_48K_CYC = CLK_HZ / RATE_48K_HZ;
  localparam int N_EFFECTS   = 16;

  // ----------------------------------------------------------------
  // Register word offsets (host address space 0x0000..0x00FF)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG     = 8'h00;
  localparam logic [7:0] OFS_QPORT   = 8'h01;
  localparam logic [7:0] OFS_CAP     = 8'h02;
  localparam logic [7:0] OFS_FREE    = 8'h03;
  localparam logic [7:0] OFS_NSTORED = 8'h04;
  localparam logic [7:0] OFS_NPLAY   = 8'h05;
  localparam logic [7:0] OFS_PLAY    = 8'h06;
  localparam logic [7:0] OFS_STATUS  = 8'h07;
  localparam logic [3:0] GRP_END     = 4'h1;
  localparam logic [3:0] GRP_IDX     = 4'h2;
  localparam logic [3:0] GRP_LOOP    = 4'h3;
  localparam int         PLAY_TRIG_BIT = 0;

  // ----------------------------------------------------------------
  // Types and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUMP = 2'b01,
    ST_RAMP = 2'b10,
    ST_RUN  = 2'b11
  } hwq_state_t;

  typedef struct packed {
    logic pump_en;
    logic gate_en;
    logic out_en;
  } hwq_pwr_t;

  typedef struct packed {
    logic [1:0] low_water_time;
    logic [1:0] sample_rate_select;
  } hwq_cfg_t;

  localparam hwq_cfg_t   CFG_RST  = '{low_water_time: 2'h0, sample_rate_select: 2'h1};
  localparam logic [7:0] LOOP_RST = 8'h01;

  // Samples left when the almost-empty pin falls: [rate][time]
  localparam logic [6:0] LW_TAB [3][4] = '{
    '{7'h01, 7'h02, 7'h04, 7'h10},
    '{7'h04, 7'h08, 7'h10, 7'h40},
    '{7'h06, 7'h0c, 7'h18, 7'h62}
  };

endpackage

// File: test/hwq_wave_engine_monitor.sv
`timescale 1ns/10ps
module hwq_wave_engine_monitor
  import hwq_pkg::*;
#(
  parameter int PUMP_TMO_CYC = PUMP_CYC,
  parameter int DIV48_CYC    = DIV_48K_CYC
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        spi_sclk,
  input wire logic        spi_cs_n,
  input wire logic        spi_mosi,
  input wire logic        spi_miso,
  input wire logic        spi_miso_oe_n,
  input wire logic        pump_ok,
  input wire logic        ramp_done,
  input wire hwq_pwr_t    pwr_ctl,
  input wire logic [11:0] dac_data,
  input wire logic        dac_strobe,
  input wire logic        fifo_low_n
);
  // ----------------------------------------------------------------
  // Counters for windows too long to unroll
  // ----------------------------------------------------------------
  logic [19:0] pump_q;
  logic [19:0] pump_d;
  logic [15:0] gap_q;
  logic [15:0] gap_d;

  assign pump_d = (!pwr_ctl.pump_en || pwr_ctl.gate_en) ? 20'h0_0000 : pump_q + 20'h0_0001;
  assign gap_d  = dac_strobe ? 16'h0000 : (&gap_q ? gap_q : gap_q + 16'h0001);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pump_q <= 20'h0_0000;
      gap_q  <= 16'hffff;
    end else begin
      pump_q <= pump_d;
      gap_q  <= gap_d;
    end
  end

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  strobe_pulse_a: assert property (dac_strobe |=> !dac_strobe)
    else $error("dac strobe longer than one cycle");
  strobe_gap_a: assert property (dac_strobe |-> gap_q >= 16'(DIV48_CYC - 1))
    else $error("dac strobes closer than the fastest sample rate");
  run_power_a: assert property (dac_strobe |-> pwr_ctl.gate_en && pwr_ctl.out_en)
    else $error("sample sent while output stage is off");
  gate_order_a: assert property ($rose(pwr_ctl.gate_en) |-> $past(pump_ok, 2))
    else $error("gate drive enabled before pumps were ready");
  pump_limit_a: assert property (pump_q <= 20'(PUMP_TMO_CYC + 4))
    else $error("charge pump start-up runs past its limit");
  low_rise_a: assert property ($rose(fifo_low_n) |-> !spi_cs_n)
    else $error("almost-empty pin released without host traffic");
  low_fall_a: assert property ($fell(fifo_low_n) |-> !spi_cs_n || $past(dac_strobe) ||
    $past(dac_strobe, 2) || $past(dac_strobe, 3))
    else $error("almost-empty pin fell without a sample or host traffic");
  dac_hold_a: assert property ($changed(dac_data) |-> dac_strobe)
    else $error("dac data changed without a strobe");
  miso_idle_a: assert property (spi_cs_n [*5] |-> spi_miso_oe_n)
    else $error("read data driven while deselected");
endmodule

bind hwq_wave_engine hwq_wave_engine_monitor #(
  .PUMP_TMO_CYC(PUMP_TMO_CYC),
  .DIV48_CYC   (DIV48_CYC)
) hwq_wave_engine_monitor_i (
  .core_clk, .rst_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n,
  .pump_ok, .ramp_done, .pwr_ctl, .dac_data, .dac_strobe, .fifo_low_n
);

// File: test/hwq_spi_host.sv
`timescale 1ns/10ps
module hwq_spi_host (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe_n
);
  logic [15:0] wq [$];
  logic [15:0] rq [$];

  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // Mode 0: data set while clock low, both sides sample on the rise
  task automatic word(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = w[i];
      #80 spi_sclk = 1'b1;
      r[i] = spi_miso & ~spi_miso_oe_n;
      #80 spi_sclk = 1'b0;
    end
  endtask

  // Odd start offset keeps the link clock out of phase with the core
  task automatic frame(input logic [15:0] cmd);
    logic [15:0] r;
    rq = {};
    #81.3 spi_cs_n = 1'b0;
    #80 word(cmd, r);
    foreach (wq[i]) begin
      word(wq[i], r);
      rq.push_back(r);
    end
    wq = {};
    #80 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #160;
  endtask
endmodule

// File: test/hwq_wave_engine_bench.sv
`timescale 1ns/10ps
module hwq_wave_engine_bench import hwq_pkg::*;;
  localparam int D8  = 40;
  localparam int D32 = 20;
  localparam int D48 = 12;

  logic        core_clk;
  logic        rst_n;
  logic        spi_sclk;
  logic        spi_cs_n;
  logic        spi_mosi;
  logic        spi_miso;
  logic        spi_miso_oe_n;
  logic        pump_ok;
  logic        ramp_done;
  hwq_pwr_t    pwr_ctl;
  logic [11:0] dac_data;
  logic        dac_strobe;
  logic        fifo_low_n;
  logic        no_pump;
  logic [11:0] mem [5];
  logic [11:0] exp_q [$];
  logic [11:0] cap_q [$];
  int          t_q [$];
  int          ord [12] = '{0, 1, 2, 4, 8, 5, 9, 3, 6, 10, 7, 11};
  int          cyc = 0;
  int          n_fail = 0;
  int          compares = 0;
  int          cnt = 0;

  hwq_wave_engine #(.PUMP_TMO_CYC(200), .DIV8_CYC(D8), .DIV32_CYC(D32), .DIV48_CYC(D48))
    hwq_wave_engine_i (.core_clk, .rst_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe_n, .pump_ok, .ramp_done, .pwr_ctl, .dac_data, .dac_strobe, .fifo_low_n);
  hwq_spi_host hwq_spi_host_i (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Analog side answers late by a random margin; samples are logged
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    pump_ok <= pwr_ctl.pump_en & ~no_pump & (pump_ok | ($urandom_range(3) == 0));
    ramp_done <= pwr_ctl.gate_en & (ramp_done | ($urandom_range(3) == 0));
    if (dac_strobe === 1'b1) begin
      cap_q.push_back(dac_data);
      t_q.push_back(cyc);
    end
    if (cyc == 110000) begin
      n_fail++;
      end_sim();
    end
  end

  function automatic int lw(input int r, input int t);
    int tab [3][4] = '{'{1, 2, 4, 16}, '{4, 8, 16, 64}, '{6, 12, 24, 98}};
    return tab[r][t];
  endfunction

  function automatic logic [15:0] cap(input int n, input int last);
    return 16'(9216 - (n == 0 ? 0 : last - 'h2000 + 1));
  endfunction

  function automatic logic [15:0] rv(input int i);
    return hwq_spi_host_i.rq[i];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic put(input logic [15:0] v);
    hwq_spi_host_i.wq.push_back(v);
  endtask

  task automatic wr(input logic [13:0] a);
    hwq_spi_host_i.frame({2'b00, a});
  endtask

  task automatic rd(input logic [13:0] a, input int n);
    repeat (n) put(16'h0000);
    hwq_spi_host_i.frame({2'b10, a});
  endtask

  task automatic qwr(input int n);
    logic [15:0] w;
    repeat (n) begin
      w = 16'($urandom);
      exp_q.push_back(w[11:0]);
      put(w);
    end
    if (n > 0) wr(14'h0001);
    cnt += n;
  endtask

  task automatic wait_idle(input int n);
    for (int k = 0; k < 5000 && cap_q.size() < n; k++) @(posedge core_clk);
    for (int k = 0; k < 4000 && pwr_ctl !== 3'b000; k++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    chk({13'h0000, pwr_ctl}, 16'h0000, "standby");
  endtask

  task automatic chk_run(input int gap);
    chk(16'(cap_q.size()), 16'(exp_q.size()), "sample count");
    foreach (exp_q[i]) if (i < cap_q.size()) begin
      chk({4'h0, cap_q[i]}, {4'h0, exp_q[i]}, "dac sample");
      if (i > 0) chk(16'(t_q[i] - t_q[i - 1]), 16'(gap), "sample period");
    end
    cap_q = {};
    t_q = {};
    exp_q = {};
  endtask

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    int r;
    int t;
    int th;
    rst_n = 1'b0;
    pump_ok = 1'b0;
    ramp_done = 1'b0;
    no_pump = 1'b0;
    void'($urandom(32'h3d41));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(14'h0000, 1);
    chk(rv(0), 16'h0001, "cfg reset");
    // Reads stop advancing at the queue port, so capacity is read apart
    rd(14'h0002, 2);
    chk(rv(0), cap(0, 0), "capacity empty");
    chk(rv(1), cap(0, 0), "free empty");
    rd(14'h0030, 3);
    for (int i = 0; i < 3; i++) chk(rv(i), 16'h0001, "loop count reset");
    rd(14'h1000, 1);
    chk(rv(0), 16'h0000, "unmapped read");
    // ----------------------------------------------------------------
    // Stored effects: slot 0 plays effect 1 twice, slot 1 effect 0 once
    // ----------------------------------------------------------------
    foreach (mem[i]) begin
      mem[i] = 12'($urandom);
      put({4'($urandom), mem[i]});
    end
    wr(14'h2000);
    put(16'h2002);
    put(16'h2004);
    wr(14'h0010);
    put(16'h0001);
    put(16'h0000);
    wr(14'h0020);
    put(16'h0002);
    put(16'h0001);
    wr(14'h0030);
    put(16'h0002);
    put(16'h0002);
    put(16'h0001);
    wr(14'h0004);
    exp_q = '{mem[3], mem[4], mem[3], mem[4], mem[0], mem[1], mem[2]};
    wait_idle(7);
    chk_run(D32);
    rd(14'h0002, 2);
    chk(rv(0), cap(2, 'h2004), "capacity shrunk");
    chk(rv(1), cap(2, 'h2004), "free shrunk");
    rd(14'h0006, 1);
    chk(rv(0), 16'h0000, "trigger self-clear");
    // Endless slot at the slow rate, stopped by the host
    put(16'h0000);
    wr(14'h0000);
    put(16'h0000);
    wr(14'h0030);
    put(16'h0001);
    put(16'h0001);
    wr(14'h0005);
    for (int k = 0; k < 3000 && cap_q.size() < 10; k++) @(posedge core_clk);
    put(16'h0000);
    wr(14'h0006);
    wait_idle(0);
    chk(16'(cap_q.size() >= 10), 16'h0001, "endless replay");
    foreach (cap_q[i]) exp_q.push_back(mem[3 + i % 2]);
    chk_run(D8);
    // Pumps never report ready: playback abandoned, nothing sent
    no_pump = 1'b1;
    put(16'h0001);
    wr(14'h0006);
    wait_idle(0);
    chk_run(0);
    rd(14'h0006, 1);
    chk(rv(0), 16'h0000, "trigger after timeout");
    // ----------------------------------------------------------------
    // Low-water table, thresholds in rising order, queue held back
    // ----------------------------------------------------------------
    foreach (ord[k]) begin
      r = ord[k] / 4;
      t = ord[k] % 4;
      th = lw(r, t);
      put(16'(t * 4 + r));
      wr(14'h0000);
      chk(16'(fifo_low_n), 16'(cnt > th), "low pin after cfg");
      if (th < 30 && cnt <= th) begin
        qwr(th - cnt);
        chk(16'(fifo_low_n), 16'h0000, "low pin at threshold");
        qwr(1);
        chk(16'(fifo_low_n), 16'h0001, "low pin above threshold");
      end
    end
    rd(14'h0002, 2);
    chk(rv(0), cap(2, 'h2004), "capacity");
    chk(rv(1), 16'(cap(2, 'h2004) - cnt), "free with data");
    no_pump = 1'b0;
    wait_idle(cnt);
    chk_run(D48);
    rd(14'h0003, 1);
    chk(rv(0), cap(2, 'h2004), "free after drain");
    end_sim();
  end
endmodule
